// ===== src/hbw_device.sv
// Device end: wait/acknowledge output, address strobe use, reset behaviour
`timescale 1ns/10ps
`default_nettype none
module hbw_device
    import hbw_pkg::*;
#(
    parameter int WAIT_CYCLES = HBW_WAIT_CYCLES
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // Configuration
    input  wire hbw_style_t            bus_style,
    // Host pins
    hbw_if.device                      bus,
    // User side: register access toward the core
    output logic                       core_wr,
    output logic                       core_rd,
    output logic [HBW_ADDR_W-1:0]      core_addr,
    output logic [HBW_DATA_W-1:0]      core_wdata,
    input  wire logic [HBW_DATA_W-1:0] core_rdata,
    output logic                       busy
);
    localparam int CW = $clog2(WAIT_CYCLES + 1);
    localparam int SW = 4 + HBW_ADDR_W + HBW_DATA_W;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE, ST_HOLD} hbw_dev_state_t;

    typedef struct packed {
        hbw_dev_state_t        state;
        logic [CW-1:0]         cnt;
        logic                  is_wr;
        logic                  ack_out;
        logic                  ack_oe_n;
        logic [HBW_DATA_W-1:0] rdata;
        logic                  core_wr;
        logic                  core_rd;
        logic [HBW_ADDR_W-1:0] core_addr;
        logic [HBW_DATA_W-1:0] core_wdata;
        logic                  busy;
    } hbw_dev_st_t;

    hbw_dev_st_t st_r;
    hbw_dev_st_t st_nxt;

    logic [SW-1:0]         pins_raw;
    logic [SW-1:0]         pins_s;
    logic                  cs_n_s;
    logic                  rd_n_s;
    logic                  wr_n_s;
    logic                  as_n_s;
    logic [HBW_ADDR_W-1:0] addr_s;
    logic [HBW_DATA_W-1:0] wdata_s;
    logic                  strobe_ok;
    logic                  access;
    logic                  style_68k;
    logic                  style_6800;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    assign pins_raw = {bus.cs_n, bus.rd_n, bus.wr_n, bus.addr_strobe_n, bus.addr, bus.wdata};

    hbw_sync3 #(
        .W    (SW),
        .INIT ({{(4){1'b1}}, {(SW-4){1'b0}}})
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in (pins_raw),
        .sync_out (pins_s)
    );

    assign {cs_n_s, rd_n_s, wr_n_s, as_n_s, addr_s, wdata_s} = pins_s;

    ////////////////////////////////////////////////////////////////////////////
    // Access decode
    assign style_68k  = (bus_style == HBW_STYLE_68K);
    assign style_6800 = (bus_style == HBW_STYLE_6800);
    // Strobe only matters in 68K style; elsewhere the host holds it high
    assign strobe_ok  = style_68k ? !as_n_s : 1'b1;
    // Style is sampled live; a change mid-transfer is not supported
    assign access     = !cs_n_s && strobe_ok && (!rd_n_s || !wr_n_s);

    ////////////////////////////////////////////////////////////////////////////
    // Transfer sequencer
    always_comb begin
        st_nxt         = st_r;
        st_nxt.core_wr = 1'b0;
        st_nxt.core_rd = 1'b0;
        unique case (st_r.state)
            ST_IDLE: begin
                st_nxt.ack_oe_n = HBW_OE_RELEASE;
                st_nxt.busy     = 1'b0;
                if (access) begin
                    st_nxt.state     = ST_WAIT;
                    st_nxt.cnt       = CW'(WAIT_CYCLES);
                    st_nxt.is_wr     = !wr_n_s;
                    st_nxt.core_addr = addr_s;
                    st_nxt.busy      = 1'b1;
                    // No drive in 6800 style: the pin is left floating
                    st_nxt.ack_oe_n  = style_6800 ? HBW_OE_RELEASE : HBW_OE_DRIVE;
                    st_nxt.ack_out   = style_68k ? HBW_ACK_WAIT_68K
                                                 : HBW_WAIT_ACTIVE_N;
                end
            end
            ST_WAIT: begin
                if (st_r.cnt == '0) begin
                    st_nxt.state = ST_DONE;
                    if (st_r.is_wr) begin
                        st_nxt.core_wr    = 1'b1;
                        st_nxt.core_wdata = wdata_s;
                    end else begin
                        st_nxt.core_rd = 1'b1;
                    end
                end else begin
                    st_nxt.cnt = st_r.cnt - CW'(1);
                end
            end
            ST_DONE: begin
                // Read data captured one cycle after the core strobe
                if (!st_r.is_wr) begin
                    st_nxt.rdata = core_rdata;
                end
                st_nxt.ack_out = style_68k ? HBW_ACK_DONE_68K
                                           : ~HBW_WAIT_ACTIVE_N;
                st_nxt.state   = ST_HOLD;
            end
            ST_HOLD: begin
                // Hold completion until the host ends the cycle, then float
                if (cs_n_s || (rd_n_s && wr_n_s)) begin
                    st_nxt.ack_oe_n = HBW_OE_RELEASE;
                    st_nxt.state    = ST_IDLE;
                    st_nxt.busy     = 1'b0;
                end
            end
        endcase
    end

    // Reset puts all outputs inactive and released
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{state: ST_IDLE, ack_oe_n: HBW_OE_RELEASE, ack_out: 1'b1,
                      default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign bus.ack_out  = st_r.ack_out;
    assign bus.ack_oe_n = st_r.ack_oe_n;
    assign bus.rdata    = st_r.rdata;
    assign core_wr      = st_r.core_wr;
    assign core_rd      = st_r.core_rd;
    assign core_addr    = st_r.core_addr;
    assign core_wdata   = st_r.core_wdata;
    assign busy         = st_r.busy;
endmodule
`default_nettype wire

// ===== src/hbw_host.sv
// Host end: drives bus cycles and waits for the completion handshake, or a fixed count in 6800 style
`timescale 1ns/10ps
`default_nettype none
module hbw_host
    import hbw_pkg::*;
(
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // Configuration, held fixed while running
    input  wire hbw_style_t            bus_style,
    // Host pins
    hbw_if.host                        bus,
    // User side
    input  wire logic                  req,
    input  wire logic                  req_wr,
    input  wire logic [HBW_ADDR_W-1:0] req_addr,
    input  wire logic [HBW_DATA_W-1:0] req_wdata,
    output logic                       ready,
    output logic                       done,
    output logic [HBW_DATA_W-1:0]      rdata
);
    localparam int FW = $clog2(HBW_FIXED_CYCLES + 1);

    typedef enum logic [1:0] {HS_IDLE, HS_WAIT, HS_END} hbw_host_state_t;

    typedef struct packed {
        hbw_host_state_t       state;
        logic                  cs_n;
        logic                  rd_n;
        logic                  wr_n;
        logic                  as_n;
        logic [HBW_ADDR_W-1:0] addr;
        logic [HBW_DATA_W-1:0] wdata;
        logic                  done;
        logic [HBW_DATA_W-1:0] rdata;
        logic                  ready;
        logic                  wait_seen;
        logic [FW-1:0]         cnt;
    } hbw_host_st_t;

    hbw_host_st_t st_r;
    hbw_host_st_t st_nxt;
    logic         ack_s;
    logic         ack_wait;
    logic         ack_done;

    // Acknowledge pin comes from another clock's logic: synchronise it
    hbw_sync3 #(
        .W    (1),
        .INIT (1'b1)
    ) u_ack_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in (bus.ack_pin),
        .sync_out (ack_s)
    );

    // Waiting level; in 68K style the released pull-up reads as waiting too
    assign ack_wait = (bus_style == HBW_STYLE_68K) ? (ack_s == HBW_ACK_WAIT_68K)
                                                   : (ack_s == HBW_WAIT_ACTIVE_N);
    // 6800 style has no handshake: the cycle simply lasts a fixed count
    assign ack_done = (bus_style == HBW_STYLE_6800) ? (st_r.cnt == '0)
                                                    : (st_r.wait_seen && !ack_wait);

    ////////////////////////////////////////////////////////////////////////////
    // Cycle sequencer
    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        unique case (st_r.state)
            HS_IDLE: begin
                if (req && st_r.ready) begin
                    st_nxt.state = HS_WAIT;
                    st_nxt.ready = 1'b0;
                    st_nxt.cs_n  = 1'b0;
                    st_nxt.rd_n  = req_wr;
                    st_nxt.wr_n  = !req_wr;
                    st_nxt.addr  = req_addr;
                    st_nxt.wdata = req_wdata;
                    st_nxt.wait_seen = 1'b0;
                    st_nxt.cnt   = FW'(HBW_FIXED_CYCLES);
                    // Strobe used only in 68K style, otherwise held high
                    st_nxt.as_n  = (bus_style == HBW_STYLE_68K) ? 1'b0
                                                                : HBW_STROBE_IDLE;
                end
            end
            HS_WAIT: begin
                // A released pin reads as done in generic style, so wait must be seen first
                if (ack_wait) begin
                    st_nxt.wait_seen = 1'b1;
                end
                if (st_r.cnt != '0) begin
                    st_nxt.cnt = st_r.cnt - FW'(1);
                end
                if (ack_done) begin
                    st_nxt.state = HS_END;
                end
            end
            HS_END: begin
                st_nxt.rdata = bus.rdata;
                st_nxt.cs_n  = 1'b1;
                st_nxt.rd_n  = 1'b1;
                st_nxt.wr_n  = 1'b1;
                st_nxt.as_n  = HBW_STROBE_IDLE;
                st_nxt.done  = 1'b1;
                st_nxt.ready = 1'b1;
                st_nxt.state = HS_IDLE;
            end
            default: begin
                st_nxt.state = HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{state: HS_IDLE, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                      as_n: HBW_STROBE_IDLE, ready: 1'b1, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs; scan test input tied low
    assign bus.cs_n             = st_r.cs_n;
    assign bus.rd_n             = st_r.rd_n;
    assign bus.wr_n             = st_r.wr_n;
    assign bus.addr_strobe_n    = st_r.as_n;
    assign bus.addr             = st_r.addr;
    assign bus.wdata            = st_r.wdata;
    assign bus.scan_test_enable = HBW_SCAN_NORMAL;
    assign ready                = st_r.ready;
    assign done                 = st_r.done;
    assign rdata                = st_r.rdata;
endmodule
`default_nettype wire

// ===== src/hbw_if.sv
// Interface joining the host end and the device end of the port
`timescale 1ns/10ps
`default_nettype none
interface hbw_if;
    import hbw_pkg::*;
    logic                  cs_n;
    logic                  rd_n;
    logic                  wr_n;
    logic                  addr_strobe_n;
    logic [HBW_ADDR_W-1:0] addr;
    logic [HBW_DATA_W-1:0] wdata;
    logic [HBW_DATA_W-1:0] rdata;
    logic                  ack_out;
    logic                  ack_oe_n;
    logic                  scan_test_enable;
    logic                  ack_pin;

    // Pin level resolved from the enable; undriven pin floats high via pull
    assign ack_pin = (ack_oe_n == HBW_OE_DRIVE) ? ack_out : 1'b1;

    modport device (
        input  cs_n, rd_n, wr_n, addr_strobe_n, addr, wdata, scan_test_enable,
        output rdata, ack_out, ack_oe_n
    );
    modport host (
        output cs_n, rd_n, wr_n, addr_strobe_n, addr, wdata, scan_test_enable,
        input  rdata, ack_pin
    );
endinterface
`default_nettype wire

// ===== src/hbw_pkg.sv
// Shared constants and types for the host bus wait/strobe/reset port
package hbw_pkg;
    // Host bus style selection
    typedef enum logic [1:0] {
        HBW_STYLE_GENERIC = 2'h0,
        HBW_STYLE_68K     = 2'h1,
        HBW_STYLE_6800    = 2'h2
    } hbw_style_t;

    // Default data width and wait cycles
    localparam int HBW_DATA_W        = 8;
    localparam int HBW_WAIT_CYCLES   = 4;
    localparam int HBW_ADDR_W        = 1;
    // Host cycle length where no handshake exists; covers pin sync plus device wait
    localparam int HBW_FIXED_CYCLES  = 16;

    // Pin levels
    localparam logic HBW_WAIT_ACTIVE_N  = 1'b0; // Generic wait, active low
    localparam logic HBW_ACK_DONE_68K   = 1'b0; // 68K acknowledge: low means done
    localparam logic HBW_ACK_WAIT_68K   = 1'b1; // 68K acknowledge: high means wait
    localparam logic HBW_OE_DRIVE       = 1'b0; // Output enable low while driving
    localparam logic HBW_OE_RELEASE     = 1'b1;
    localparam logic HBW_STROBE_IDLE    = 1'b1;
    localparam logic HBW_SCAN_NORMAL    = 1'b0;
endpackage

// ===== src/hbw_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module hbw_sync3
    import hbw_pkg::*;
#(
    parameter int      W        = 1,
    parameter logic [W-1:0] INIT = '1
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] out;
    } hbw_sync_st_t;

    hbw_sync_st_t st_r;
    hbw_sync_st_t st_nxt;

    // First stage feeds only the second; output follows once stages 2 and 3 agree
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = async_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < W; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.out[i] = st_r.s3[i];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= {4{INIT}};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.out;
endmodule
`default_nettype wire

// ===== testbench/hbw_monitor.sv
// Checker for the wait/acknowledge and strobe wires between the two ends
`timescale 1ns/10ps
`default_nettype none
module hbw_monitor
    import hbw_pkg::*;
(
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst_n,
    // Configuration
    input wire hbw_style_t bus_style,
    // Host side strobes
    input wire logic       cs_n,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic       addr_strobe_n,
    input wire logic       scan_test_enable,
    // Device side pin
    input wire logic       ack_out,
    input wire logic       ack_oe_n
);
    logic wait_lvl;
    logic idle;

    // Waiting level: high in 68K style, low in the generic style
    assign wait_lvl = (bus_style == HBW_STYLE_68K) ? HBW_ACK_WAIT_68K : HBW_WAIT_ACTIVE_N;
    // Host not addressing the device; strobe only counts in 68K style
    assign idle = cs_n || (rd_n && wr_n) || ((bus_style == HBW_STYLE_68K) && addr_strobe_n);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////
    // Reset and idle behaviour
    a_reset_inactive: assert property ($rose(rst_n) |-> ack_oe_n && cs_n && rd_n && wr_n)
        else $error("pins not inactive after reset");
    // Synchroniser delay means release may lag the host by several cycles
    a_idle_released: assert property (idle [*8] |-> ack_oe_n == HBW_OE_RELEASE)
        else $error("ack driven while host idle");
    a_release_after: assert property ($rose(cs_n) && !ack_oe_n |-> ##[1:8] ack_oe_n)
        else $error("ack not released after cycle end");
    a_no_drive_6800: assert property (bus_style == HBW_STYLE_6800 |-> ack_oe_n)
        else $error("ack driven in 6800 style");
    a_strobe_held_high: assert property (bus_style != HBW_STYLE_68K |-> addr_strobe_n)
        else $error("strobe low outside 68K style");
    a_scan_grounded: assert property (scan_test_enable == HBW_SCAN_NORMAL)
        else $error("scan test input not grounded");

    ////////////////////////////////////////////////////////////////////////////
    // Wait then completion sequence
    a_gen_wait_first: assert property ($fell(ack_oe_n) && bus_style == HBW_STYLE_GENERIC
        |-> ack_out == HBW_WAIT_ACTIVE_N)
        else $error("generic wait not low at start");
    a_68k_wait_first: assert property ($fell(ack_oe_n) && bus_style == HBW_STYLE_68K
        |-> ack_out == HBW_ACK_WAIT_68K)
        else $error("68K acknowledge not waiting at start");
    a_wait_then_done: assert property ($fell(ack_oe_n) |-> (!ack_oe_n && ack_out == wait_lvl) [*5]
        ##[1:3] (!ack_oe_n && ack_out != wait_lvl))
        else $error("wait length or completion wrong");
    a_done_holds: assert property (!ack_oe_n && ack_out != wait_lvl
        |=> ack_oe_n || ack_out != wait_lvl)
        else $error("completion level not held");

    c_transfer: cover property ($fell(ack_oe_n));
endmodule
`default_nettype wire

// ===== testbench/host_bus_wait_strobe_reset_pins_tb.sv
// Bench joining host end and device end, driven from the host user side
`timescale 1ns/10ps
`default_nettype none
module host_bus_wait_strobe_reset_pins_tb;
    import hbw_pkg::*;
    localparam int WAITS = HBW_WAIT_CYCLES;
    logic                  sys_clk;
    logic                  rst_n;
    hbw_style_t            bus_style;
    logic                  req;
    logic                  req_wr;
    logic [HBW_ADDR_W-1:0] req_addr;
    logic [HBW_DATA_W-1:0] req_wdata;
    logic                  ready;
    logic                  done;
    logic [HBW_DATA_W-1:0] rdata;
    logic                  core_wr;
    logic                  core_rd;
    logic [HBW_ADDR_W-1:0] core_addr;
    logic [HBW_DATA_W-1:0] core_wdata;
    logic [HBW_DATA_W-1:0] core_rdata;
    logic                  busy;
    logic [HBW_ADDR_W-1:0] last_addr;
    logic [HBW_DATA_W-1:0] last_data;
    int                    fails;
    int                    compares;
    int                    cycles;
    int                    wait_cnt;
    int                    drive_cnt;
    int                    wr_cnt;
    int                    rd_cnt;

    hbw_if hbw_if_inst ();
    hbw_device #(.WAIT_CYCLES(WAITS)) hbw_device_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .bus_style(bus_style), .bus(hbw_if_inst), .core_wr(core_wr), .core_rd(core_rd),
        .core_addr(core_addr), .core_wdata(core_wdata), .core_rdata(core_rdata), .busy(busy));
    hbw_host hbw_host_inst (.sys_clk(sys_clk), .rst_n(rst_n), .bus_style(bus_style),
        .bus(hbw_if_inst), .req(req), .req_wr(req_wr), .req_addr(req_addr),
        .req_wdata(req_wdata), .ready(ready), .done(done), .rdata(rdata));
    hbw_monitor hbw_monitor_inst (.sys_clk(sys_clk), .rst_n(rst_n), .bus_style(bus_style),
        .cs_n(hbw_if_inst.cs_n), .rd_n(hbw_if_inst.rd_n), .wr_n(hbw_if_inst.wr_n),
        .addr_strobe_n(hbw_if_inst.addr_strobe_n), .scan_test_enable(hbw_if_inst.scan_test_enable),
        .ack_out(hbw_if_inst.ack_out), .ack_oe_n(hbw_if_inst.ack_oe_n));

    ////////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Wire and core side observation; also cuts a hang short
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (hbw_if_inst.ack_oe_n === HBW_OE_DRIVE) begin
            drive_cnt = drive_cnt + 1;
            if (hbw_if_inst.ack_pin === ((bus_style == HBW_STYLE_68K) ? 1'b1 : 1'b0))
                wait_cnt = wait_cnt + 1;
        end
        if (core_wr === 1'b1) begin
            wr_cnt = wr_cnt + 1;
            last_addr = core_addr;
            last_data = core_wdata;
        end
        if (core_rd === 1'b1)
            rd_cnt = rd_cnt + 1;
        if (cycles >= 5000) begin
            fails = fails + 1;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Style only changes while reset is held, so pin roles never move mid-cycle
    task automatic do_reset(input hbw_style_t s);
        @(negedge sys_clk);
        rst_n = 1'b0;
        bus_style = s;
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        wait_cnt = 0;
        drive_cnt = 0;
        wr_cnt = 0;
        rd_cnt = 0;
    endtask

    task automatic issue(input logic wr, input logic [HBW_ADDR_W-1:0] a,
                         input logic [HBW_DATA_W-1:0] d);
        int i;
        @(negedge sys_clk);
        for (i = 0; i < 200 && ready !== 1'b1; i++)
            @(negedge sys_clk);
        // Idle gap so the device sees the previous cycle end and releases
        repeat (4) @(negedge sys_clk);
        req = 1'b1;
        req_wr = wr;
        req_addr = a;
        req_wdata = d;
        @(negedge sys_clk);
        req = 1'b0;
    endtask

    task automatic finish(input logic wr, input logic [HBW_DATA_W-1:0] exp);
        int i;
        for (i = 0; i < 200 && done !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        check("done", done, 1'b1);
        if (!wr)
            check("rdata", rdata, exp);
    endtask

    // Write, read, second write in one style
    task automatic run_style(input hbw_style_t s);
        do_reset(s);
        core_rdata = 8'h3c;
        issue(1'b1, 1'b0, 8'ha5);
        finish(1'b1, 8'h00);
        issue(1'b0, 1'b1, 8'h00);
        finish(1'b0, 8'h3c);
        issue(1'b1, 1'b1, 8'h5a);
        finish(1'b1, 8'h00);
        repeat (10) @(negedge sys_clk);
        if (s != HBW_STYLE_6800) begin
            check("wr_cnt", wr_cnt, 8'h02);
            check("rd_cnt", rd_cnt, 8'h01);
            check("core_addr", last_addr, 8'h01);
            check("core_wdata", last_data, 8'h5a);
            check("waits", wait_cnt >= 3 * (WAITS + 1), 1'b1);
        end else
            check("drive_cnt", drive_cnt, 8'h00);
        check("ack_oe_n", hbw_if_inst.ack_oe_n, HBW_OE_RELEASE);
        check("ack_pin", hbw_if_inst.ack_pin, 1'b1);
        $display("Test style %0d ended", s);
    endtask

    task automatic stop_test();
        $display("Counts: %0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int i;
        rst_n = 1'b0;
        bus_style = HBW_STYLE_GENERIC;
        {req, req_wr, req_addr, req_wdata, core_rdata} = '0;
        {fails, compares, cycles} = '0;
        run_style(HBW_STYLE_GENERIC);
        run_style(HBW_STYLE_68K);
        run_style(HBW_STYLE_6800);
        // Reset in mid-transfer while the device is driving
        do_reset(HBW_STYLE_68K);
        issue(1'b1, 1'b0, 8'h11);
        for (i = 0; i < 100 && hbw_if_inst.ack_oe_n !== HBW_OE_DRIVE; i++)
            @(negedge sys_clk);
        rst_n = 1'b0;
        #1;
        check("rst ack_oe_n", hbw_if_inst.ack_oe_n, HBW_OE_RELEASE);
        check("rst core_wr", core_wr, 1'b0);
        check("rst busy", busy, 1'b0);
        check("rst ready", ready, 1'b1);
        check("rst cs_n", hbw_if_inst.cs_n, 1'b1);
        do_reset(HBW_STYLE_68K);
        issue(1'b0, 1'b0, 8'h00);
        finish(1'b0, 8'h3c);
        check("wr_cnt after reset", wr_cnt, 8'h00);
        $display("Test reset ended");
        stop_test();
    end
endmodule
`default_nettype wire
